// >>> core/ftcb_pkg.sv
// equalizer filter coefficient bank, channel A taps two to seven
// constants shared by the bank top and its coefficient store
package ftcb_pkg;

  // ----------------------------------------------------------------
  // bus and address layout
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 16;
  localparam int          DATA_W       = 32;
  localparam int          IDX_W        = 14;
  localparam int          ADDR_LSB     = 2;
  localparam logic [1:0]  ALIGN_OK     = 2'h0;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CFG    = 14'h0400;
  localparam logic [IDX_W-1:0] IDX_LINK   = 14'h0401;
  localparam logic [IDX_W-1:0] IDX_STAT   = 14'h0402;
  localparam logic [IDX_W-1:0] IDX_TAP2   = 14'h041A;
  localparam logic [IDX_W-1:0] IDX_TAP3   = 14'h041C;
  localparam logic [IDX_W-1:0] IDX_TAP4   = 14'h041E;
  localparam logic [IDX_W-1:0] IDX_CENTER = 14'h0420;
  localparam logic [IDX_W-1:0] IDX_TAP6   = 14'h0423;
  localparam logic [IDX_W-1:0] IDX_TAP7   = 14'h0425;

  // ----------------------------------------------------------------
  // coefficient store layout
  // ----------------------------------------------------------------
  localparam int         SLOTS        = 6;
  localparam int         SLOT_W       = 3;
  localparam int         WORD_W       = 24;
  localparam int         SIDE_REG_W   = 16;
  localparam int         SIDE_W       = 12;
  localparam int         CENTER_W     = 18;
  localparam int         SIDE_MSB     = 11;
  localparam int         CENTER_MSB   = 17;
  localparam logic [2:0] SLOT_TAP2    = 3'h0;
  localparam logic [2:0] SLOT_TAP3    = 3'h1;
  localparam logic [2:0] SLOT_TAP4    = 3'h2;
  localparam logic [2:0] SLOT_CENTER  = 3'h3;
  localparam logic [2:0] SLOT_TAP6    = 3'h4;
  localparam logic [2:0] SLOT_TAP7    = 3'h5;
  localparam logic [WORD_W-1:0] COEFF_RESET = 24'h000000;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  localparam int         CFG_W        = 8;
  localparam int         MODE_LO      = 0;
  localparam int         SCW_LO       = 2;
  localparam int         MERGE_BIT    = 5;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [1:0] MODE_ENABLE  = 2'h2;
  localparam logic [2:0] SCW_MAX      = 3'h6;
  localparam int         SCW_BIAS     = 16;
  localparam int         LINK_EN_BIT  = 0;
  localparam int         STAT_ACT_BIT = 0;
  localparam int         STAT_LATE_BIT = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RESP = 3'b100
  } ftcb_bus_state_t;

endpackage : ftcb_pkg

// >>> core/ftcb_coeff_mem.sv
// coefficient store: one flop word per tap, registered read port
// assumes a single writer and reader on the register clock
`timescale 1ns/100ps
module ftcb_coeff_mem
  import ftcb_pkg::*;
#(
  parameter int DEPTH = SLOTS,
  parameter int WIDTH = WORD_W
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // write port
  input  wire logic                    we,
  input  wire logic [SLOT_W-1:0]       waddr,
  input  wire logic [WIDTH-1:0]        wdata,
  // read port
  input  wire logic [SLOT_W-1:0]       raddr,
  output logic      [WIDTH-1:0]        rdata,
  // every word, straight from its flops, for the filter taps
  output logic      [DEPTH-1:0][WIDTH-1:0] words
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        words[i] <= COEFF_RESET[WIDTH-1:0];
      end
    end else if (we && (int'(waddr) < DEPTH)) begin
      words[waddr] <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // registered read
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= COEFF_RESET[WIDTH-1:0];
    end else if (int'(raddr) < DEPTH) begin
      rdata <= words[raddr];
    end else begin
      rdata <= COEFF_RESET[WIDTH-1:0];
    end
  end

endmodule : ftcb_coeff_mem

// >>> core/ftcb_bank.sv
// equalizer filter coefficient bank for channel A, taps two to seven
// APB slave on pclk; filter datapath and other taps sit elsewhere
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps

// Overview of operation
// [R1] side tap registers: 12-bit signed coefficient, four upper bits stored, reset zero
// [R2] first register here feeds tap two, channel A or merged filter
// [R3] second register feeds tap three, channel A or merged filter
// [R4] third register feeds tap four, channel A or merged filter
// [R5] centre register feeds tap five, channel A or merged filter
// [R6] centre tap: 18-bit signed in 24-bit register, six upper bits stored
// [R7] fifth register feeds tap six, channel A or merged filter
// [R8] sixth register feeds tap seven, channel A or merged filter
// [R9] readback shows coefficient MSB as zero; filter still uses written value
// [R10] all coefficient registers, centre included, hold zero after reset
// [R11] filter runs only when mode field is two; zero disables it
// [R12] software sets merge control whenever single-channel mode is used
// [R13] software changes coefficients only while serial output enable is zero
// [R14] side coefficient LSB weighs two to side weight minus sixteen, zero to six
module ftcb_bank
  import ftcb_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // coefficients to the filter datapath
  output logic [SIDE_W-1:0]      chan_a_tap2_value,
  output logic [SIDE_W-1:0]      chan_a_tap3_value,
  output logic [SIDE_W-1:0]      chan_a_tap4_value,
  output logic [CENTER_W-1:0]    chan_a_center_value,
  output logic [SIDE_W-1:0]      chan_a_tap6_value,
  output logic [SIDE_W-1:0]      chan_a_tap7_value,
  // filter configuration
  output logic                   filter_enable,
  output logic                   filter_merge_ctrl,
  output logic [2:0]             side_weight_setting,
  output logic                   serial_output_enable
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic [SLOT_W:0] slot_of(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    logic [SLOT_W:0]  r;
    idx = a[ADDR_W-1:ADDR_LSB];
    r   = '0;
    if (a[ADDR_LSB-1:0] == ALIGN_OK) begin
      case (idx)
        IDX_TAP2:   r = {1'b1, SLOT_TAP2};
        IDX_TAP3:   r = {1'b1, SLOT_TAP3};
        IDX_TAP4:   r = {1'b1, SLOT_TAP4};
        IDX_CENTER: r = {1'b1, SLOT_CENTER};
        IDX_TAP6:   r = {1'b1, SLOT_TAP6};
        IDX_TAP7:   r = {1'b1, SLOT_TAP7};
        default:    r = '0;
      endcase
    end
    return r;
  endfunction : slot_of

  function automatic logic is_own(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[ADDR_W-1:ADDR_LSB];
    return (a[ADDR_LSB-1:0] == ALIGN_OK) &&
           ((idx == IDX_CFG) || (idx == IDX_LINK) || (idx == IDX_STAT));
  endfunction : is_own

  // readback view: msb of the coefficient reads as zero
  function automatic logic [DATA_W-1:0] rd_view(input logic [SLOT_W-1:0] s,
                                                input logic [WORD_W-1:0] w);
    logic [DATA_W-1:0] v;
    v = '0;
    if (s == SLOT_CENTER) begin
      v[WORD_W-1:0]   = w;
      v[CENTER_MSB]   = 1'b0;                              // R9
    end else begin
      v[SIDE_REG_W-1:0] = w[SIDE_REG_W-1:0];               // R1
      v[SIDE_MSB]       = 1'b0;                            // R9
    end
    return v;
  endfunction : rd_view

  // ----------------------------------------------------------------
  // bus sequencing
  // ----------------------------------------------------------------
  ftcb_bus_state_t state;
  ftcb_bus_state_t next_state;

  logic                   setup_phase;
  logic                   done;
  logic                   wr_done;
  logic [SLOT_W:0]        cur_slot;
  logic                   slot_hit;
  logic                   own_hit;

  assign setup_phase = psel && !penable;
  assign done        = psel && penable && pready;
  assign wr_done     = done && pwrite && !pslverr;
  assign cur_slot    = slot_of(paddr);
  assign slot_hit    = cur_slot[SLOT_W];
  assign own_hit     = is_own(paddr);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (setup_phase) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (psel && penable) begin
          next_state = ST_RESP;
        end
      end
      ST_RESP:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // coefficient store
  // ----------------------------------------------------------------
  logic [WORD_W-1:0]             mem_rdata;
  logic [SLOTS-1:0][WORD_W-1:0]  mem_words;
  logic                          mem_we;
  logic [WORD_W-1:0]             mem_wdata;

  // reserved upper bits are stored like the coefficient
  assign mem_we    = wr_done && slot_hit;
  assign mem_wdata = (cur_slot[SLOT_W-1:0] == SLOT_CENTER) ?
                     pwdata[WORD_W-1:0] :
                     {{(WORD_W-SIDE_REG_W){1'b0}}, pwdata[SIDE_REG_W-1:0]};

  ftcb_coeff_mem #(
    .DEPTH (SLOTS),
    .WIDTH (WORD_W)
  ) u_store (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (mem_we),
    .waddr   (cur_slot[SLOT_W-1:0]),
    .wdata   (mem_wdata),
    .raddr   (cur_slot[SLOT_W-1:0]),
    .rdata   (mem_rdata),
    .words   (mem_words)
  );

  // filter taps see the full written value, msb included
  assign chan_a_tap2_value   = mem_words[SLOT_TAP2][SIDE_W-1:0];     // R2
  assign chan_a_tap3_value   = mem_words[SLOT_TAP3][SIDE_W-1:0];     // R3
  assign chan_a_tap4_value   = mem_words[SLOT_TAP4][SIDE_W-1:0];     // R4
  assign chan_a_center_value = mem_words[SLOT_CENTER][CENTER_W-1:0]; // R5
  assign chan_a_tap6_value   = mem_words[SLOT_TAP6][SIDE_W-1:0];     // R7
  assign chan_a_tap7_value   = mem_words[SLOT_TAP7][SIDE_W-1:0];     // R8

  // ----------------------------------------------------------------
  // configuration and link control
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] cfg;
  logic [2:0]       wr_scw;
  logic             late_change;
  logic             is_cfg;
  logic             is_link;
  logic             is_stat;

  assign is_cfg  = own_hit && (paddr[ADDR_W-1:ADDR_LSB] == IDX_CFG);
  assign is_link = own_hit && (paddr[ADDR_W-1:ADDR_LSB] == IDX_LINK);
  assign is_stat = own_hit && (paddr[ADDR_W-1:ADDR_LSB] == IDX_STAT);
  assign wr_scw  = pwdata[SCW_LO +: 3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CFG_RESET;
    end else if (wr_done && is_cfg) begin
      cfg <= pwdata[CFG_W-1:0];
    end
  end

  // mode values other than two keep the filter idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_enable       <= 1'b0;
      filter_merge_ctrl   <= 1'b0;
      side_weight_setting <= CFG_RESET[SCW_LO +: 3];
    end else if (wr_done && is_cfg) begin
      filter_enable       <= (pwdata[MODE_LO +: 2] == MODE_ENABLE);     // R11
      filter_merge_ctrl   <= pwdata[MERGE_BIT];                         // R12
      // a reserved weight above six is held at six for the datapath
      side_weight_setting <= (wr_scw > SCW_MAX) ? SCW_MAX : wr_scw;     // R14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_output_enable <= 1'b0;
    end else if (wr_done && is_link) begin
      serial_output_enable <= pwdata[LINK_EN_BIT];
    end
  end

  // sticky flag: coefficient or config written while the link runs;
  // a new offence in the clearing cycle keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      late_change <= 1'b0;
    end else if (wr_done && (slot_hit || is_cfg) && serial_output_enable) begin
      late_change <= 1'b1;                                              // R13
    end else if (wr_done && is_stat && pwdata[STAT_LATE_BIT]) begin
      late_change <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // response
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_prdata;

  always_comb begin
    next_prdata = '0;
    if (slot_hit) begin
      next_prdata = rd_view(cur_slot[SLOT_W-1:0], mem_rdata);           // R9
    end else if (is_cfg) begin
      next_prdata[CFG_W-1:0] = cfg;
    end else if (is_link) begin
      next_prdata[LINK_EN_BIT] = serial_output_enable;
    end else if (is_stat) begin
      next_prdata[STAT_ACT_BIT]  = filter_enable;
      next_prdata[STAT_LATE_BIT] = late_change;
    end
  end

  // answer one cycle into the access phase; store read data is
  // already registered from the setup cycle by then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (state == ST_WAIT && psel && penable) begin
      pready  <= 1'b1;
      pslverr <= !(slot_hit || own_hit);
      prdata  <= pwrite ? '0 : next_prdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable;
  endsequence

  sequence access_s;
    psel && penable && !pready;
  endsequence

  sequence wr_side_s(logic [SLOT_W-1:0] s);
    wr_done && slot_hit && (cur_slot[SLOT_W-1:0] == s);
  endsequence

  bus_answer_a: assert property (
    setup_s ##1 access_s |=> pready)
    else $error("no answer one cycle into access phase");

  side_mask_a: assert property ( // R9
    done && !pwrite && slot_hit && (cur_slot[SLOT_W-1:0] != SLOT_CENTER)
      |-> (prdata[SIDE_MSB] == 1'b0) && (prdata[DATA_W-1:SIDE_REG_W] == '0))
    else $error("side readback msb or upper bits not zero");

  center_mask_a: assert property ( // R9
    done && !pwrite && slot_hit && (cur_slot[SLOT_W-1:0] == SLOT_CENTER)
      |-> (prdata[CENTER_MSB] == 1'b0) && (prdata[DATA_W-1:WORD_W] == '0))
    else $error("centre readback msb or upper bits not zero");

  tap2_write_a: assert property ( // R2
    wr_side_s(SLOT_TAP2) |=> chan_a_tap2_value == $past(pwdata[SIDE_W-1:0]))
    else $error("tap two not updated by its write");

  tap3_write_a: assert property ( // R3
    wr_side_s(SLOT_TAP3) |=> chan_a_tap3_value == $past(pwdata[SIDE_W-1:0]))
    else $error("tap three not updated by its write");

  tap4_write_a: assert property ( // R4
    wr_side_s(SLOT_TAP4) |=> chan_a_tap4_value == $past(pwdata[SIDE_W-1:0]))
    else $error("tap four not updated by its write");

  center_write_a: assert property ( // R5
    wr_side_s(SLOT_CENTER) |=>
      chan_a_center_value == $past(pwdata[CENTER_W-1:0]))
    else $error("centre tap not updated by its write");

  tap6_write_a: assert property ( // R7
    wr_side_s(SLOT_TAP6) |=> chan_a_tap6_value == $past(pwdata[SIDE_W-1:0]))
    else $error("tap six not updated by its write");

  tap7_write_a: assert property ( // R8
    wr_side_s(SLOT_TAP7) |=> chan_a_tap7_value == $past(pwdata[SIDE_W-1:0]))
    else $error("tap seven not updated by its write");

  tap_hold_a: assert property ( // R1
    !mem_we |=> $stable(mem_words))
    else $error("coefficient changed without a write");

  reset_zero_a: assert property ( // R10
    @(posedge pclk) disable iff (1'b0)
    !presetn |=> (mem_words == '0) && !filter_enable)
    else $error("coefficients not zero after reset");

  mode_enable_a: assert property ( // R11
    wr_done && is_cfg |=>
      filter_enable == ($past(pwdata[MODE_LO +: 2]) == MODE_ENABLE))
    else $error("filter enable does not follow mode two");

  weight_range_a: assert property ( // R14
    side_weight_setting <= SCW_MAX)
    else $error("side weight above six");

  late_flag_a: assert property ( // R13
    wr_done && slot_hit && serial_output_enable |=> late_change)
    else $error("write under live link not flagged");

endmodule : ftcb_bank

// >>> dv/tb_ftcb_bank.sv
// self-checking bench for the channel A coefficient bank
// assumes the bank top alone on one 200 MHz clock, driven over APB
`timescale 1ns/100ps
module tb_ftcb_bank
  import ftcb_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [SIDE_W-1:0] chan_a_tap2_value;
  logic [SIDE_W-1:0] chan_a_tap3_value;
  logic [SIDE_W-1:0] chan_a_tap4_value;
  logic [CENTER_W-1:0] chan_a_center_value;
  logic [SIDE_W-1:0] chan_a_tap6_value;
  logic [SIDE_W-1:0] chan_a_tap7_value;
  logic              filter_enable;
  logic              filter_merge_ctrl;
  logic [2:0]        side_weight_setting;
  logic              serial_output_enable;
  logic [23:0]       tap_out [6];
  logic [31:0]       rd_q;
  logic              err_q;
  int                fails;
  int                tests_run;

  localparam logic [IDX_W-1:0] IDX_TAB [6] =
    '{IDX_TAP2, IDX_TAP3, IDX_TAP4, IDX_CENTER, IDX_TAP6, IDX_TAP7};

  assign tap_out[0] = {12'h000, chan_a_tap2_value};
  assign tap_out[1] = {12'h000, chan_a_tap3_value};
  assign tap_out[2] = {12'h000, chan_a_tap4_value};
  assign tap_out[3] = {6'h00, chan_a_center_value};
  assign tap_out[4] = {12'h000, chan_a_tap6_value};
  assign tap_out[5] = {12'h000, chan_a_tap7_value};

  ftcb_bank dut (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .chan_a_tap2_value    (chan_a_tap2_value),
    .chan_a_tap3_value    (chan_a_tap3_value),
    .chan_a_tap4_value    (chan_a_tap4_value),
    .chan_a_center_value  (chan_a_center_value),
    .chan_a_tap6_value    (chan_a_tap6_value),
    .chan_a_tap7_value    (chan_a_tap7_value),
    .filter_enable        (filter_enable),
    .filter_merge_ctrl    (filter_merge_ctrl),
    .side_weight_setting  (side_weight_setting),
    .serial_output_enable (serial_output_enable)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // one full transfer; the edge first keeps release and next setup apart
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [1:0] lo,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, lo};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      $display("wrong value pready: expected 1, seen %b", pready);
      finish_test();
    end
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one more edge so the written value has left the flops before a check looks
  task automatic reg_write(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, 2'h0, wd);
    @(posedge pclk);
  endtask : reg_write

  task automatic reg_read(input logic [IDX_W-1:0] idx);
    apb(1'b0, idx, 2'h0, 32'h0000_0000);
  endtask : reg_read

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    for (int i = 0; i < 6; i++) begin
      check("tap output at reset", {8'h00, tap_out[i]}, 32'h0000_0000);
      reg_read(IDX_TAB[i]);
      check("coefficient at reset", rd_q, 32'h0000_0000);
    end
    check("filter enable at reset", {31'h0, filter_enable}, 32'h0000_0000);
    $display("test reset done");
  endtask : test_reset

  // all six written first, so a crossed decode shows in the readback
  task automatic test_coeff(input logic [31:0] base);
    logic [31:0] wd;
    int          msb;
    int          w;
    for (int i = 0; i < 6; i++) begin
      reg_write(IDX_TAB[i], base + 32'(i));
    end
    for (int i = 0; i < 6; i++) begin
      wd  = base + 32'(i);
      w   = (i == 3) ? 24 : 16;
      msb = (i == 3) ? CENTER_MSB : SIDE_MSB;
      reg_read(IDX_TAB[i]);
      check("coefficient error flag", {31'h0, err_q}, 32'h0000_0000);
      check("coefficient readback", rd_q,
            wd & ((32'h1 << w) - 32'h1) & ~(32'h1 << msb));
      check("tap output", {8'h00, tap_out[i]},
            wd & ((32'h1 << (msb + 1)) - 32'h1));
    end
    $display("test coefficients %h done", base);
  endtask : test_coeff

  // every mode code, merge both ways, side weight up to the reserved seven
  task automatic test_config();
    logic [31:0] cfg;
    for (int m = 0; m < 4; m++) begin
      cfg = 32'(m) | (32'(m & 1) << 5) | (32'(m + 4) << 2) | 32'h0000_0080;
      reg_write(IDX_CFG, cfg);
      reg_read(IDX_CFG);
      check("config readback", rd_q, cfg);
      check("filter enable", {31'h0, filter_enable}, 32'(m == 2));
      check("merge control", {31'h0, filter_merge_ctrl}, 32'(m & 1));
      check("side weight", {29'h0, side_weight_setting}, 32'((m + 4 > 6) ? 6 : m + 4));
    end
    reg_write(IDX_CFG, 32'h0000_0000);
    check("side weight zero", {29'h0, side_weight_setting}, 32'h0000_0000);
    $display("test config done");
  endtask : test_config

  // misaligned write and unmapped read must leave tap two alone
  task automatic test_errors();
    apb(1'b1, IDX_TAP2, 2'h1, 32'h0000_0777);
    check("misaligned error", {31'h0, err_q}, 32'h0000_0001);
    apb(1'b0, 14'h041B, 2'h0, 32'h0000_0000);
    check("unmapped error", {31'h0, err_q}, 32'h0000_0001);
    check("unmapped data", rd_q, 32'h0000_0000);
    reg_read(IDX_TAP2);
    check("tap two kept", rd_q, 32'h0000_5456);
    check("tap two output kept", {20'h0, chan_a_tap2_value}, 32'h0000_0456);
    $display("test errors done");
  endtask : test_errors

  // a write while the serial link runs is flagged, not blocked
  task automatic test_late_change();
    reg_write(IDX_LINK, 32'h0000_0001);
    check("link enable", {31'h0, serial_output_enable}, 32'h0000_0001);
    reg_write(IDX_TAP3, 32'h0000_0321);
    reg_read(IDX_STAT);
    check("late flag set", rd_q & 32'h3, 32'h0000_0002);
    check("tap three late", {20'h0, chan_a_tap3_value}, 32'h0000_0321);
    reg_write(IDX_LINK, 32'h0000_0000);
    reg_write(IDX_STAT, 32'h0000_0002);
    reg_read(IDX_STAT);
    check("late flag cleared", rd_q & 32'h3, 32'h0000_0000);
    $display("test late change done");
  endtask : test_late_change

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    fails     = 0;
    tests_run = 0;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 16'h0000;
    pwdata    = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_coeff(32'hFFFF_F8A0);
    test_coeff(32'h0000_5456);
    test_config();
    test_errors();
    test_late_change();
    finish_test();
  end
endmodule : tb_ftcb_bank
